//--- hdl/ppc_top.sv
// Pad pull-up, port E function and external request control with APB registers
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.svh"
module ppc_top #(
  parameter int PE_WIDTH = 6
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Port E pads, timer C ch0..1 and timer D ch0..3
  input wire logic [PE_WIDTH-1:0] i_pe_pad,
  output logic [PE_WIDTH-1:0] o_pe_pad_out,
  output logic [PE_WIDTH-1:0] o_pe_pad_oe,
  output logic [PE_WIDTH-1:0] o_pe_pad_pullup,
  // Timer side of the shared pins
  input wire logic [PE_WIDTH-1:0] i_timer_out,
  input wire logic [PE_WIDTH-1:0] i_timer_oe,
  output logic [PE_WIDTH-1:0] o_timer_in,
  // CAN pads
  input wire logic i_can_tx_data,
  output logic o_can_tx_out,
  output logic o_can_tx_oe,
  output logic o_can_tx_pullup,
  input wire logic i_can_rx_pad,
  output logic o_can_rx_data,
  output logic o_can_rx_pullup,
  // External requests
  input wire logic [1:0] i_ext_request_n,
  input wire logic i_low_power,
  input wire logic [1:0] i_irq_ack,
  output logic [1:0] o_irq_request,
  output logic [1:0] o_irq_pullup,
  output ppc_pkg::ppc_mode_type o_pe0_mode
);
  import ppc_pkg::*;

  generate
    if (PE_WIDTH < 1 || PE_WIDTH > 8) begin : g_bad_width
      $error("PE_WIDTH must be 1 to 8");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic addr_mapped(input logic [11:0] a);
    case (a)
      `PPC_OFF_PE_DOUT, `PPC_OFF_PE_DIR, `PPC_OFF_PE_FUNC, `PPC_OFF_PE_PUE,
      `PPC_OFF_PORT_PUE, `PPC_OFF_PE_OD, `PPC_OFF_SYS_PUD, `PPC_OFF_IRQ_CTRL,
      `PPC_OFF_STATUS: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic ppc_mode_type pad_mode(input logic func, input logic dir,
                                            input logic od);
    if (!func) begin
      pad_mode = PPC_MODE_TIMER;
    end else if (!dir) begin
      pad_mode = PPC_MODE_INPUT;
    end else if (od) begin
      pad_mode = PPC_MODE_OPEN;
    end else begin
      pad_mode = PPC_MODE_PUSH;
    end
  endfunction

  function automatic ppc_pad_type pad_drive(input ppc_mode_type m, input logic d,
                                            input logic pue, input logic toe);
    pad_drive = '{out: 1'b0, oe: 1'b0, pull: 1'b0};
    case (m)
      PPC_MODE_INPUT: pad_drive = '{out: 1'b0, oe: 1'b0, pull: pue};
      PPC_MODE_PUSH: pad_drive = '{out: d, oe: 1'b1, pull: 1'b0};
      PPC_MODE_OPEN: pad_drive = '{out: 1'b0, oe: ~d, pull: d & pue};
      PPC_MODE_TIMER: pad_drive = '{out: d, oe: toe, pull: pue & ~toe};
      default: pad_drive = '{out: 1'b0, oe: 1'b0, pull: 1'b0};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [PE_WIDTH-1:0] dout_reg, dout_next;
  logic [PE_WIDTH-1:0] dir_reg, dir_next;
  logic [PE_WIDTH-1:0] func_reg, func_next;
  logic [PE_WIDTH-1:0] pue_reg, pue_next;
  logic [PE_WIDTH-1:0] od_reg, od_next;
  logic ppe_reg, ppe_next;
  logic [1:0] pud_reg, pud_next;
  logic [1:0] edge_reg, edge_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic [31:0] status;
  logic wr_en;
  logic setup;

  // Input synchronisers
  logic [PE_WIDTH-1:0] pe_meta_reg, pe_sync_reg;
  logic rx_meta_reg, rx_sync_reg;

  ppc_irq_if irq_bus ();

  assign setup = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & i_pwrite & i_pstrb[0] & addr_mapped(i_paddr);

  always_comb begin
    status = 32'h0;
    status[PE_WIDTH-1:0] = pe_sync_reg;
    status[`PPC_ST_CAN_RX] = rx_sync_reg;
    status[`PPC_ST_REQ_LO +: 2] = irq_bus.sync_req;
    status[`PPC_ST_PEND_LO +: 2] = irq_bus.pending;
  end

  always_comb begin
    dout_next = dout_reg;
    dir_next = dir_reg;
    func_next = func_reg;
    pue_next = pue_reg;
    od_next = od_reg;
    ppe_next = ppe_reg;
    pud_next = pud_reg;
    edge_next = edge_reg;
    if (wr_en) begin
      case (i_paddr)
        `PPC_OFF_PE_DOUT: dout_next = i_pwdata[PE_WIDTH-1:0];
        `PPC_OFF_PE_DIR: dir_next = i_pwdata[PE_WIDTH-1:0];
        `PPC_OFF_PE_FUNC: func_next = i_pwdata[PE_WIDTH-1:0];
        `PPC_OFF_PE_PUE: pue_next = i_pwdata[PE_WIDTH-1:0];
        `PPC_OFF_PORT_PUE: ppe_next = i_pwdata[`PPC_PPE_CAN_TX];
        `PPC_OFF_PE_OD: od_next = i_pwdata[PE_WIDTH-1:0];
        `PPC_OFF_SYS_PUD: pud_next = i_pwdata[1:0];
        `PPC_OFF_IRQ_CTRL: edge_next = i_pwdata[1:0];
        default: ;
      endcase
    end
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (setup) begin
      err_next = ~addr_mapped(i_paddr);
      case (i_paddr)
        `PPC_OFF_PE_DOUT: rdata_next = {{(32-PE_WIDTH){1'b0}}, dout_reg};
        `PPC_OFF_PE_DIR: rdata_next = {{(32-PE_WIDTH){1'b0}}, dir_reg};
        `PPC_OFF_PE_FUNC: rdata_next = {{(32-PE_WIDTH){1'b0}}, func_reg};
        `PPC_OFF_PE_PUE: rdata_next = {{(32-PE_WIDTH){1'b0}}, pue_reg};
        `PPC_OFF_PORT_PUE: rdata_next = {31'h0, ppe_reg};
        `PPC_OFF_PE_OD: rdata_next = {{(32-PE_WIDTH){1'b0}}, od_reg};
        `PPC_OFF_SYS_PUD: rdata_next = {30'h0, pud_reg};
        `PPC_OFF_IRQ_CTRL: rdata_next = {30'h0, edge_reg};
        `PPC_OFF_STATUS: rdata_next = status;
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      dout_reg <= '0;
      dir_reg <= '0;
      func_reg <= '0;
      pue_reg <= '1;
      od_reg <= '0;
      ppe_reg <= `PPC_RST_PORT_PUE;
      pud_reg <= `PPC_RST_SYS_PUD;
      edge_reg <= `PPC_RST_IRQ_CTRL;
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      dir_reg <= dir_next;
      func_reg <= func_next;
      pue_reg <= pue_next;
      od_reg <= od_next;
      ppe_reg <= ppe_next;
      pud_reg <= pud_next;
      edge_reg <= edge_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign o_pready = 1'b1;
  assign o_prdata = rdata_reg;
  assign o_pslverr = err_reg & i_psel & i_penable;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pe_meta_reg <= '1;
      pe_sync_reg <= '1;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      pe_meta_reg <= i_pe_pad;
      pe_sync_reg <= pe_meta_reg;
      rx_meta_reg <= i_can_rx_pad;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  assign o_timer_in = pe_sync_reg;
  assign o_can_rx_data = rx_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive
  logic [PE_WIDTH-1:0] pe_out_reg, pe_out_next;
  logic [PE_WIDTH-1:0] pe_oe_reg, pe_oe_next;
  logic [PE_WIDTH-1:0] pe_pull_reg, pe_pull_next;
  ppc_pad_type can_tx_reg, can_tx_next;
  logic rx_pull_reg, rx_pull_next;
  logic [1:0] irq_pull_reg, irq_pull_next;

  always_comb begin
    ppc_pad_type p;
    p = '{out: 1'b0, oe: 1'b0, pull: 1'b0};
    for (int i = 0; i < PE_WIDTH; i++) begin
      p = pad_drive(pad_mode(func_reg[i], dir_reg[i], od_reg[i]),
                    func_reg[i] ? dout_reg[i] : i_timer_out[i], pue_reg[i],
                    i_timer_oe[i]);
      pe_out_next[i] = p.out;
      pe_oe_next[i] = p.oe;
      pe_pull_next[i] = p.pull;
    end
    can_tx_next = pad_drive(PPC_MODE_OPEN, i_can_tx_data, ppe_reg, 1'b0);
    rx_pull_next = ~pud_reg[`PPC_PUD_CAN];
    irq_pull_next = {2{~pud_reg[`PPC_PUD_IRQ]}};
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pe_out_reg <= '0;
      pe_oe_reg <= '0;
      pe_pull_reg <= '1;
      can_tx_reg <= '{out: 1'b0, oe: 1'b0, pull: 1'b1};
      rx_pull_reg <= 1'b1;
      irq_pull_reg <= 2'h3;
    end else begin
      pe_out_reg <= pe_out_next;
      pe_oe_reg <= pe_oe_next;
      pe_pull_reg <= pe_pull_next;
      can_tx_reg <= can_tx_next;
      rx_pull_reg <= rx_pull_next;
      irq_pull_reg <= irq_pull_next;
    end
  end

  assign o_pe_pad_out = pe_out_reg;
  assign o_pe_pad_oe = pe_oe_reg;
  assign o_pe_pad_pullup = pe_pull_reg;
  assign o_can_tx_out = can_tx_reg.out;
  assign o_can_tx_oe = can_tx_reg.oe;
  assign o_can_tx_pullup = can_tx_reg.pull;
  assign o_can_rx_pullup = rx_pull_reg;
  assign o_irq_pullup = irq_pull_reg;
  assign o_pe0_mode = pad_mode(func_reg[0], dir_reg[0], od_reg[0]);

  ////////////////////////////////////////////////////////////////////////////
  // External requests
  assign irq_bus.edge_mode = edge_reg;
  assign irq_bus.ack = i_irq_ack;

  ppc_irq_cond u_irq_cond (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_ext_request_n(i_ext_request_n),
    .bus(irq_bus)
  );

  // Clockless path while the clock may be stopped
  assign o_irq_request = i_low_power ? irq_bus.wake : irq_bus.sync_req;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_od_low_nopull: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (func_reg[0] && dir_reg[0] && od_reg[0] && !dout_reg[0])
    |=> (o_pe_pad_oe[0] && !o_pe_pad_out[0] && !o_pe_pad_pullup[0]))
    else $error("open-drain low kept pull-up");
  a_od_high_pull: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (func_reg[0] && dir_reg[0] && od_reg[0] && dout_reg[0])
    |=> (!o_pe_pad_oe[0] && o_pe_pad_pullup[0] == $past(pue_reg[0])))
    else $error("open-drain high pull-up wrong");
  a_push_nopull: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (func_reg[0] && dir_reg[0] && !od_reg[0])
    |=> (o_pe_pad_oe[0] && !o_pe_pad_pullup[0] && o_pe_pad_out[0] == $past(dout_reg[0])))
    else $error("push-pull pad has pull-up");
  a_can_tx_od: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ##1 (o_can_tx_oe == !$past(i_can_tx_data)) && !o_can_tx_out
    && (o_can_tx_pullup == ($past(i_can_tx_data) && $past(ppe_reg))))
    else $error("CAN transmit pad not open-drain");
  a_dir_input: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (func_reg[1] && !dir_reg[1]) |=> !o_pe_pad_oe[1])
    else $error("input port pin drives");
  a_timer_route: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !func_reg[0] |=> (o_pe_pad_oe[0] == $past(i_timer_oe[0])
    && o_pe_pad_out[0] == $past(i_timer_out[0])))
    else $error("timer pin not routed to timer");
  a_pue_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !pue_reg[0] |=> !o_pe_pad_pullup[0])
    else $error("cleared pull-up still on");
  a_irq_pull_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    pud_reg[`PPC_PUD_IRQ] |=> (o_irq_pullup == 2'h0))
    else $error("request pin pull-up not disabled");
  a_canrx_pull_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ##1 o_can_rx_pullup == !$past(pud_reg[`PPC_PUD_CAN]))
    else $error("CAN receive pull-up wrong");
  a_async_wake: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_low_power && !i_ext_request_n[0]) |-> o_irq_request[0])
    else $error("low-power request not passed");
endmodule // ppc_top
`default_nettype wire

//--- hdl/ppc_consts.svh
// Offsets, field positions, reset values and functional notes for pad control
// Functional notes
// - Open-drain pad driving low: pull-up off
// - Open-drain high: pull-up on unless enable cleared
// - Push-pull output pad: pull-up always off
// - CAN transmit open-drain, pull-up on at reset
// - Port pins individually input or output
// - Timer C/D pins default to timer function
// - Cleared port E pull-up bit disables pull-up
// - Stop/wait: requests accepted without the clock
// - Other modes: requests synchronised before use
// - Each request level or falling-edge selectable
// - Disable bit turns request pin pull-ups off
// - Disable bit turns CAN receive pull-up off
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define PPC_OFF_PE_DOUT 12'h000
`define PPC_OFF_PE_DIR 12'h004
`define PPC_OFF_PE_FUNC 12'h008
`define PPC_OFF_PE_PUE 12'h00c
`define PPC_OFF_PORT_PUE 12'h010
`define PPC_OFF_PE_OD 12'h014
`define PPC_OFF_SYS_PUD 12'h018
`define PPC_OFF_IRQ_CTRL 12'h01c
`define PPC_OFF_STATUS 12'h020

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define PPC_PPE_CAN_TX 0
`define PPC_PUD_IRQ 0
`define PPC_PUD_CAN 1
`define PPC_ST_CAN_RX 8
`define PPC_ST_REQ_LO 9
`define PPC_ST_PEND_LO 11

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define PPC_RST_PORT_PUE 1'h1
`define PPC_RST_SYS_PUD 2'h0
`define PPC_RST_IRQ_CTRL 2'h0

////////////////////////////////////////////////////////////////////////////////
// Timing
`define PPC_SYNC_STAGES 2

`endif

//--- hdl/ppc_pkg.sv
// Types shared by the pad control modules
package ppc_pkg;
  typedef enum logic [1:0] {
    PPC_MODE_INPUT = 2'b00,
    PPC_MODE_PUSH = 2'b01,
    PPC_MODE_OPEN = 2'b10,
    PPC_MODE_TIMER = 2'b11
  } ppc_mode_type;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull;
  } ppc_pad_type;
endpackage

//--- hdl/ppc_irq_if.sv
// Carrier between pad control and request conditioning
`timescale 1ns/1ps
`default_nettype none
interface ppc_irq_if;
  logic [1:0] edge_mode;
  logic [1:0] ack;
  logic [1:0] level_n;
  logic [1:0] pending;
  logic [1:0] sync_req;
  logic [1:0] wake;
  modport ctrl (output edge_mode, output ack, input level_n, input pending,
                input sync_req, input wake);
  modport cond (input edge_mode, input ack, output level_n, output pending,
                output sync_req, output wake);
endinterface
`default_nettype wire

//--- hdl/ppc_irq_cond.sv
// External request synchroniser, edge detector and asynchronous wake path
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.svh"
module ppc_irq_cond #(
  parameter int SYNC_STAGES = `PPC_SYNC_STAGES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Request pins, active low
  input wire logic [1:0] i_ext_request_n,
  // Carrier
  ppc_irq_if.cond bus
);
  import ppc_pkg::*;

  generate
    if (SYNC_STAGES < 2) begin : g_bad_stages
      $error("SYNC_STAGES must be at least 2");
    end
  endgenerate

  logic [SYNC_STAGES-1:0] sync_reg [2];
  logic [SYNC_STAGES-1:0] sync_next [2];
  logic [1:0] prev_reg, prev_next;
  logic [1:0] pend_reg, pend_next;
  logic [1:0] req_reg, req_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sync_next[i] = {sync_reg[i][SYNC_STAGES-2:0], i_ext_request_n[i]};
      prev_next[i] = sync_reg[i][SYNC_STAGES-1];
      // Falling edge sets, acknowledge clears, set wins
      pend_next[i] = bus.edge_mode[i] &
                     ((prev_reg[i] & ~sync_reg[i][SYNC_STAGES-1]) |
                      (pend_reg[i] & ~bus.ack[i]));
      req_next[i] = bus.edge_mode[i] ? pend_next[i] :
                    ~sync_reg[i][SYNC_STAGES-1];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_reg[0] <= '1;
      sync_reg[1] <= '1;
      prev_reg <= 2'h3;
      pend_reg <= 2'h0;
      req_reg <= 2'h0;
    end else begin
      sync_reg[0] <= sync_next[0];
      sync_reg[1] <= sync_next[1];
      prev_reg <= prev_next;
      pend_reg <= pend_next;
      req_reg <= req_next;
    end
  end

  assign bus.level_n = {sync_reg[1][SYNC_STAGES-1], sync_reg[0][SYNC_STAGES-1]};
  assign bus.pending = pend_reg;
  assign bus.sync_req = req_reg;
  assign bus.wake = ~i_ext_request_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Latency figure holds for the two-stage build only
  generate
    if (SYNC_STAGES == 2) begin : g_lag_check
      a_level_sync_lag: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (!bus.edge_mode[0] && !i_ext_request_n[0])[*3] |=> bus.sync_req[0])
        else $error("level request not seen after synchroniser");
    end
  endgenerate
  a_edge_sets_pend: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (bus.edge_mode[0] && $fell(bus.level_n[0])) |=> bus.pending[0])
    else $error("falling edge did not set pending");
  a_edge_set_wins: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (bus.edge_mode[1] && $fell(bus.level_n[1]) && bus.ack[1]) |=> bus.pending[1])
    else $error("acknowledge lost a new edge");
  a_level_no_pend: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !bus.edge_mode[0] |=> !bus.pending[0])
    else $error("pending set in level mode");
endmodule // ppc_irq_cond
`default_nettype wire

//--- tb/ppc_ext_model.sv
// Behavioural model of the external devices wired to the port E and request pins
`timescale 1ns/1ps
`default_nettype none
module ppc_ext_model (
  // Clock
  input wire logic i_mclk,
  // Pad controls from the device
  input wire logic [5:0] i_pad_out,
  input wire logic [5:0] i_pad_oe,
  input wire logic [5:0] i_pad_pullup,
  input wire logic [1:0] i_irq_pullup,
  // External drive commands
  input wire logic [5:0] i_ext_en,
  input wire logic [5:0] i_ext_val,
  input wire logic [1:0] i_need_service,
  // Resolved pin levels
  output logic [5:0] o_pad,
  output logic [1:0] o_request_n
);
  logic toggle_reg;

  initial toggle_reg = 1'b0;
  // Floating lines wander every cycle
  always @(posedge i_mclk) begin
    toggle_reg <= ~toggle_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wire resolution
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_pad[i] = i_pad_oe[i] ? i_pad_out[i] : i_ext_en[i] ? i_ext_val[i] :
                 i_pad_pullup[i] ? 1'b1 : toggle_reg;
    end
    for (int k = 0; k < 2; k++) begin
      o_request_n[k] = i_need_service[k] ? 1'b0 : i_irq_pullup[k] ? 1'b1 : toggle_reg;
    end
  end
endmodule // ppc_ext_model
`default_nettype wire

//--- tb/pin_pad_pullup_irq_control_bench.sv
// Self-checking bench for pad pull-up, port E and request control
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module pin_pad_pullup_irq_control_bench;
  import ppc_pkg::*;
  logic i_mclk, i_rstn, psel, penable, pwrite, pready, pslverr, err, low_power;
  logic can_tx, can_rx, can_tx_out, can_tx_oe, can_tx_pull, can_rx_data, can_rx_pull;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] pad, pout, poe, ppull, tout, toe, tin, ext_en, ext_val, m;
  logic [5:0] r_dat, r_dir, r_fn, r_pue, r_od;
  logic [1:0] req_n, ack, irq_req, irq_pull, need;
  logic [11:0] raddr [6] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h018, 12'h01c};
  logic [31:0] rexp [6] = '{32'h0, 32'h0, 32'h3f, 32'h1, 32'h0, 32'h0};
  ppc_mode_type mode;
  int errors, checks_done, cycles, seed;

  ppc_top u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pe_pad(pad),
    .o_pe_pad_out(pout), .o_pe_pad_oe(poe), .o_pe_pad_pullup(ppull), .i_timer_out(tout),
    .i_timer_oe(toe), .o_timer_in(tin), .i_can_tx_data(can_tx), .o_can_tx_out(can_tx_out),
    .o_can_tx_oe(can_tx_oe), .o_can_tx_pullup(can_tx_pull), .i_can_rx_pad(can_rx),
    .o_can_rx_data(can_rx_data), .o_can_rx_pullup(can_rx_pull), .i_ext_request_n(req_n),
    .i_low_power(low_power), .i_irq_ack(ack), .o_irq_request(irq_req),
    .o_irq_pullup(irq_pull), .o_pe0_mode(mode));

  ppc_ext_model u_ext (.i_mclk(i_mclk), .i_pad_out(pout), .i_pad_oe(poe),
    .i_pad_pullup(ppull), .i_irq_pullup(irq_pull), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .i_need_service(need), .o_pad(pad), .o_request_n(req_n));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timeout
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expectations
  function automatic logic [17:0] pad_exp(input logic [5:0] fn, dir, od, dat, pue, to, te);
    logic [5:0] oe, o, pl;
    for (int i = 0; i < 6; i++) begin
      oe[i] = !fn[i] ? te[i] : (dir[i] & (!od[i] | !dat[i]));
      o[i] = !fn[i] ? to[i] & te[i] : (dir[i] & !od[i] & dat[i]);
      pl[i] = !fn[i] ? pue[i] & !te[i] : !dir[i] ? pue[i] : od[i] & dat[i] & pue[i];
    end
    return {oe, o, pl};
  endfunction

  function automatic ppc_mode_type mode_exp(input logic fn, dir, od);
    return !fn ? PPC_MODE_TIMER : !dir ? PPC_MODE_INPUT : od ? PPC_MODE_OPEN : PPC_MODE_PUSH;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus and timing tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    n = 0;
    @(posedge i_mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 50) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic conclude();
    $display("Errors %0d, comparisons %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 44478;
    {i_rstn, psel, penable, pwrite, paddr, pwdata, low_power, can_rx} = '0;
    {tout, toe, ext_en, ext_val, ack, need} = '0;
    can_tx = 1'b1;
    repeat (20) @(posedge i_mclk);
    `CHK({ppull, poe, can_tx_pull, can_rx_pull, irq_pull}, {6'h3f, 6'h0, 4'hf})
    i_rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, raddr[i], 32'h0);
      `CHK(rd, rexp[i])
    end
    `CHK(mode, PPC_MODE_TIMER)
    for (int i = 0; i < 16; i++) begin
      r_fn = (i == 0) ? 6'h3f : (i == 1) ? 6'h0 : 6'($random(seed));
      {r_dat, r_dir, r_pue, r_od} = 24'($random(seed));
      apb(1'b1, 12'h000, {26'h0, r_dat});
      apb(1'b1, 12'h004, {26'h0, r_dir});
      apb(1'b1, 12'h008, {26'h0, r_fn});
      apb(1'b1, 12'h00c, {26'h0, r_pue});
      apb(1'b1, 12'h014, {26'h0, r_od});
      tout <= 6'($random(seed));
      toe <= 6'($random(seed));
      ext_en <= 6'($random(seed));
      ext_val <= 6'($random(seed));
      tick(4);
      `CHK({poe, pout & poe, ppull}, pad_exp(r_fn, r_dir, r_od, r_dat, r_pue, tout, toe))
      `CHK(mode, mode_exp(r_fn[0], r_dir[0], r_od[0]))
      m = poe | ext_en | ppull;
      `CHK(tin & m, pad & m)
    end
    for (int i = 0; i < 8; i++) begin
      r_pue = 6'($random(seed));
      apb(1'b1, 12'h010, {31'h0, r_pue[0]});
      can_tx <= r_pue[1];
      can_rx <= r_pue[2];
      tick(3);
      `CHK({can_tx_out, can_tx_oe, can_tx_pull, can_rx_data}, {1'b0, ~can_tx, can_tx & r_pue[0], can_rx})
    end
    apb(1'b1, 12'h01c, 32'h0);
    @(posedge i_mclk);
    need <= 2'b01;
    tick(1);
    `CHK(irq_req, 2'b00)
    tick(3);
    `CHK(irq_req, 2'b01)
    @(posedge i_mclk);
    need <= 2'b00;
    tick(4);
    `CHK(irq_req, 2'b00)
    apb(1'b1, 12'h01c, 32'h2);
    @(posedge i_mclk);
    need <= 2'b10;
    tick(2);
    @(posedge i_mclk);
    need <= 2'b00;
    tick(5);
    `CHK(irq_req, 2'b10)
    @(posedge i_mclk);
    ack <= 2'b10;
    @(posedge i_mclk);
    ack <= 2'b00;
    tick(2);
    `CHK(irq_req, 2'b00)
    @(posedge i_mclk);
    need <= 2'b10;
    tick(1);
    @(posedge i_mclk);
    ack <= 2'b10;
    @(posedge i_mclk);
    ack <= 2'b00;
    need <= 2'b00;
    tick(2);
    `CHK(irq_req, 2'b10)
    @(posedge i_mclk);
    low_power <= 1'b1;
    tick(2);
    @(posedge i_mclk);
    need <= 2'b01;
    #1;
    `CHK(irq_req[0], 1'b1)
    @(posedge i_mclk);
    need <= 2'b00;
    low_power <= 1'b0;
    tick(4);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h018, k);
      tick(2);
      `CHK({can_rx_pull, irq_pull}, {~k[1], {2{~k[0]}}})
    end
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    tick(2);
    conclude();
  end
endmodule // pin_pad_pullup_irq_control_bench
`default_nettype wire
